// >>> verilog/logic_branch_pkg.sv
// Constants shared by the logic-and-branch execute block.
// Assumes a 32-bit instruction word and a 64-bit register path.
package logic_branch_pkg;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int XLEN = 64;
    localparam int REG_IDX_W = 5;
    localparam int OPC_LSB = 26;
    localparam int RS_LSB = 21;
    localparam int RT_LSB = 16;
    localparam int RD_LSB = 11;
    localparam int IMM_W = 16;
    localparam int BR_SHIFT = 2;
    localparam int COND32_BITS = 32;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [5:0] OPC_SPECIAL = 6'h00;
    localparam logic [5:0] FUNC_CONJ = 6'h24;
    localparam logic [5:0] OPC_CONJ_IMM = 6'h0c;
    localparam logic [5:0] OPC_EQ = 6'h04;
    localparam logic [5:0] OPC_EQ_LIKELY = 6'h14;
    localparam logic [5:0] OPC_REG_IMM_GROUP = 6'h01;
    localparam logic [3:0] OPC_COP_GROUP_HI = 4'h4;
    localparam logic [4:0] COP_SUB_BRANCH = 5'h08;
    localparam logic [4:0] COND_FALSE_CODE = 5'h00;
    localparam logic [4:0] COND_TRUE_CODE = 5'h01;
    localparam logic [4:0] COND_FALSE_LIKELY_CODE = 5'h02;
    localparam logic [4:0] COND_TRUE_LIKELY_CODE = 5'h03;
    localparam logic [4:0] NONNEG_CODE = 5'h01;

    // ------------------------------------------------------------------
    // Reset value and PC step
    // ------------------------------------------------------------------
    localparam logic [XLEN-1:0] PC_RESET = 64'hffff_ffff_bfc0_0000;
    localparam logic [XLEN-1:0] PC_STEP = 64'h0000_0000_0000_0004;

    // Branch sequencing states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_SLOT = 3'b010,
        SEQ_NULL = 3'b100
    } seq_state_t;

endpackage

// >>> verilog/branch_decode.sv
// Combinational decoder that classifies one instruction word.
// Assumes the word is stable for the cycle it is presented.
`timescale 1ns/1ps
module branch_decode
    import logic_branch_pkg::*;
(
    input wire logic [31:0] i_instr,
    output logic o_conj_reg,
    output logic o_conj_imm,
    output logic o_cop_branch,
    output logic o_cop_on_true,
    output logic o_eq_branch,
    output logic o_nonneg_branch,
    output logic o_likely
);
    logic [5:0] opc;
    logic [4:0] sub;
    logic [4:0] code;

    // ------------------------------------------------------------------
    // Field extraction and class decode
    // ------------------------------------------------------------------
    assign opc = i_instr[31:OPC_LSB];
    assign sub = i_instr[25:RS_LSB];
    assign code = i_instr[20:RT_LSB];

    // Register form needs the function field too
    assign o_conj_reg = (opc == OPC_SPECIAL) &&
        (i_instr[5:0] == FUNC_CONJ); // see (RULE1)
    assign o_conj_imm = (opc == OPC_CONJ_IMM); // see (RULE2)
    // Low two opcode bits select the coprocessor; only 0 is handled here
    assign o_cop_branch = (opc[5:2] == OPC_COP_GROUP_HI) &&
        (opc[1:0] == 2'h0) && (sub == COP_SUB_BRANCH) &&
        (code == COND_FALSE_CODE || code == COND_TRUE_CODE ||
         code == COND_FALSE_LIKELY_CODE ||
         code == COND_TRUE_LIKELY_CODE); // see (RULE6) see (RULE9)
    assign o_cop_on_true = code[0]; // see (RULE8)
    assign o_eq_branch = (opc == OPC_EQ) || (opc == OPC_EQ_LIKELY);
    assign o_nonneg_branch = (opc == OPC_REG_IMM_GROUP) &&
        (code == NONNEG_CODE); // see (RULE14)
    // Likely: equality-likely opcode or cop code with bit 1 set
    assign o_likely = (opc == OPC_EQ_LIKELY) ||
        (o_cop_branch && code[1]); // see (RULE9) see (RULE13)
endmodule

// >>> verilog/logic_and_branch_exec.sv
// Execute stage for bitwise conjunction and a set of conditional branches.
// Assumes operands are read from the register file in the issue cycle and
// the coprocessor condition line comes from logic on the same clock.
//
// Contract
// (RULE1) Register conjunction writes rs AND rt
// (RULE2) Immediate zero-extended, ANDed, written to rt
// (RULE3) Target is delay-slot address plus shifted offset
// (RULE4) Redirect happens after the delay slot
// (RULE5) Likely forms nullify slot when not taken
// (RULE6) Coprocessor branch opcode 0100xx, sub 01000; the decoder accepts only opcode 010000
// (RULE7) False form taken when sampled condition low
// (RULE8) True form code 00001, taken when high
// (RULE9) Likely cop codes 00010 and 00011
// (RULE10) Software spaces condition change from branch
// (RULE11) Unusable coprocessor raises an exception
// (RULE12) Equality branch taken when registers equal
// (RULE13) Likely equality nullifies slot otherwise
// (RULE14) Nonnegative branch taken when rs not negative
// (RULE15) 64-bit mode sign-extends offset fully
`timescale 1ns/1ps
module logic_and_branch_exec
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_issue,
    input wire logic [31:0] i_instr,
    input wire logic [logic_branch_pkg::XLEN-1:0] i_rs_val,
    input wire logic [logic_branch_pkg::XLEN-1:0] i_rt_val,
    input wire logic i_mode64,
    input wire logic i_coprocessor_condition_line,
    input wire logic i_cop_usable,
    output logic o_wr_en,
    output logic [4:0] o_wr_idx,
    output logic [logic_branch_pkg::XLEN-1:0] o_wr_data,
    output logic [logic_branch_pkg::XLEN-1:0] o_pc,
    output logic o_redirect,
    output logic o_nullify,
    output logic o_cop_unusable
);
    import logic_branch_pkg::*;
    logic cop_trap;
    logic conj_reg;
    logic conj_imm;
    logic cop_branch;
    logic cop_on_true;
    logic eq_branch;
    logic nonneg_branch;
    logic likely;
    logic is_branch;
    logic cond_sampled;
    logic cond_met;
    logic [XLEN-1:0] offset_ext;
    logic [XLEN-1:0] slot_addr;
    logic [XLEN-1:0] next_target;
    logic [XLEN-1:0] target;
    logic take;
    logic slot_nullified;
    seq_state_t state;
    seq_state_t next_state;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    branch_decode u_decode (
        .i_instr(i_instr),
        .o_conj_reg(conj_reg),
        .o_conj_imm(conj_imm),
        .o_cop_branch(cop_branch),
        .o_cop_on_true(cop_on_true),
        .o_eq_branch(eq_branch),
        .o_nonneg_branch(nonneg_branch),
        .o_likely(likely)
    );

    assign is_branch = cop_branch || eq_branch || nonneg_branch;

    // Condition line is registered on every issue, so a branch sees the
    // value from the instruction before it; software must leave a gap
    // after changing it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cond_sampled <= 1'b0;
        end else if (i_issue) begin // see (RULE7) see (RULE10)
            cond_sampled <= i_coprocessor_condition_line;
        end
    end

    // ------------------------------------------------------------------
    // Branch condition and target
    // ------------------------------------------------------------------
    always_comb begin
        cond_met = 1'b0;
        if (cop_branch) begin
            cond_met = cop_on_true ? cond_sampled
                                   : !cond_sampled; // see (RULE7) see (RULE8)
        end else if (eq_branch) begin
            cond_met = (i_rs_val == i_rt_val); // see (RULE12) see (RULE13)
        end else if (nonneg_branch) begin
            // Sign bit depends on address mode
            cond_met = i_mode64 ? !i_rs_val[XLEN-1]
                                : !i_rs_val[COND32_BITS-1]; // see (RULE14)
        end
    end

    // Offset shifted then sign-extended to the full width
    assign offset_ext = {{(XLEN-IMM_W-BR_SHIFT){i_instr[IMM_W-1]}},
        i_instr[IMM_W-1:0], {BR_SHIFT{1'b0}}}; // see (RULE15)
    assign slot_addr = o_pc + PC_STEP;
    // 32-bit mode keeps the address a sign-extended word
    always_comb begin
        next_target = slot_addr + offset_ext; // see (RULE3)
        if (!i_mode64) begin
            next_target = {{(XLEN-COND32_BITS){next_target[31]}},
                next_target[31:0]};
        end
    end

    // Coprocessor branch without usability is trapped, never taken
    assign cop_trap = cop_branch && !i_cop_usable; // see (RULE11)
    assign take = i_issue && is_branch && cond_met && !cop_trap;

    // ------------------------------------------------------------------
    // Delay-slot sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            SEQ_IDLE: begin
                if (take) begin
                    next_state = SEQ_SLOT; // see (RULE4)
                end else if (i_issue && likely && !cop_trap) begin
                    next_state = SEQ_NULL; // see (RULE5)
                end
            end
            // The slot instruction, squashed or not, ends the sequence
            SEQ_SLOT, SEQ_NULL: begin
                if (i_issue) begin
                    next_state = SEQ_IDLE;
                end
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= SEQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Target is held until the slot instruction issues
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            target <= '0;
        end else if (take && state == SEQ_IDLE) begin
            target <= next_target; // see (RULE3)
        end
    end

    // Slot instruction of a not-taken likely branch is squashed
    assign slot_nullified = (state == SEQ_NULL); // see (RULE5) see (RULE13)

    // ------------------------------------------------------------------
    // Program counter and flow outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pc <= PC_RESET;
            o_redirect <= 1'b0;
            o_nullify <= 1'b0;
        end else begin
            o_redirect <= 1'b0;
            o_nullify <= 1'b0;
            if (i_issue) begin
                if (state == SEQ_SLOT) begin
                    o_pc <= target; // see (RULE4)
                    o_redirect <= 1'b1;
                end else begin
                    o_pc <= slot_addr;
                end
                o_nullify <= slot_nullified;
            end
        end
    end

    // Coprocessor unusable trap pulse
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_cop_unusable <= 1'b0;
        end else begin
            o_cop_unusable <= i_issue && cop_branch && !i_cop_usable &&
                !slot_nullified; // see (RULE11)
        end
    end

    // ------------------------------------------------------------------
    // Register write-back
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_wr_en <= 1'b0;
            o_wr_idx <= '0;
            o_wr_data <= '0;
        end else begin
            o_wr_en <= 1'b0;
            if (i_issue && !slot_nullified) begin
                if (conj_reg) begin
                    o_wr_en <= 1'b1;
                    o_wr_idx <= i_instr[15:RD_LSB];
                    o_wr_data <= i_rs_val & i_rt_val; // see (RULE1)
                end else if (conj_imm) begin
                    o_wr_en <= 1'b1;
                    o_wr_idx <= i_instr[20:RT_LSB];
                    o_wr_data <= {{(XLEN-IMM_W){1'b0}}, // see (RULE2)
                        i_instr[IMM_W-1:0] & i_rs_val[IMM_W-1:0]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_conj_reg;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && conj_reg && !slot_nullified) |=>
            o_wr_en && o_wr_data == ($past(i_rs_val) & $past(i_rt_val));
    endproperty
    a_conj_reg: assert property (p_conj_reg) // see (RULE1)
        else $error("conjunction result wrong");
    property p_conj_imm;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && conj_imm && !slot_nullified) |=>
            o_wr_en && o_wr_data[XLEN-1:IMM_W] == '0;
    endproperty
    a_conj_imm: assert property (p_conj_imm) // see (RULE2)
        else $error("immediate result not zero-extended");
    property p_slot_first;
        @(posedge i_clk) disable iff (i_srst)
        (take && state == SEQ_IDLE) |=> !o_redirect;
    endproperty
    a_slot_first: assert property (p_slot_first) // see (RULE4)
        else $error("redirect before delay slot");
    property p_redirect_target;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && state == SEQ_SLOT) |=> o_redirect && o_pc == target;
    endproperty
    a_redirect_target: assert property (p_redirect_target) // see (RULE3)
        else $error("redirect pc not target");
    // Squashed slot must show the pulse and must not write back
    property p_likely_null;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && slot_nullified) |=> o_nullify && !o_wr_en;
    endproperty
    a_likely_null: assert property (p_likely_null) // see (RULE5)
        else $error("likely slot not nullified");
    property p_taken_no_null;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && state == SEQ_SLOT && conj_reg) |=> o_wr_en && !o_nullify;
    endproperty
    a_taken_no_null: assert property (p_taken_no_null) // see (RULE13)
        else $error("taken slot nullified");
    property p_cop_trap;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && cop_branch && !i_cop_usable && !slot_nullified) |=>
            o_cop_unusable && !o_redirect;
    endproperty
    a_cop_trap: assert property (p_cop_trap) // see (RULE11)
        else $error("unusable trap missing");
    property p_false_taken;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && cop_branch && !cop_on_true && i_cop_usable &&
         state == SEQ_IDLE) |-> (take == !cond_sampled);
    endproperty
    a_false_taken: assert property (p_false_taken) // see (RULE7)
        else $error("false form condition wrong");
    property p_eq_taken;
        @(posedge i_clk) disable iff (i_srst)
        (i_issue && eq_branch) |-> (take == (i_rs_val == i_rt_val));
    endproperty
    a_eq_taken: assert property (p_eq_taken) // see (RULE12)
        else $error("equality branch decision wrong");
    c_taken: cover property (@(posedge i_clk) disable iff (i_srst)
        (i_issue && state == SEQ_SLOT) ##1 o_redirect);
    c_nullify: cover property (@(posedge i_clk) disable iff (i_srst)
        o_nullify);
    c_trap: cover property (@(posedge i_clk) disable iff (i_srst)
        o_cop_unusable);
endmodule

// >>> verif/cond_line_model.sv
// Model of the coprocessor condition line and its usable flag.
// Assumes the bench requests new levels just after a rising edge.
`timescale 1ns/1ps
module cond_line_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_req_cond,
    input wire logic i_req_usable,
    output logic o_cond,
    output logic o_usable
);
    // ------------------------------------------------------------------
    // Condition bit and usable flag
    // ------------------------------------------------------------------
    // Registered like a real control bit, so a request lands one edge late
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_cond <= 1'b0;
            o_usable <= 1'b1;
        end else begin
            o_cond <= i_req_cond;
            o_usable <= i_req_usable;
        end
    end
endmodule

// >>> verif/logic_and_branch_exec_test.sv
// Self-checking bench for the logic-and-branch execute block.
// Assumes one issue at a time; outputs are read at the falling edge.
`timescale 1ns/1ps
module logic_and_branch_exec_test;
    import logic_branch_pkg::*;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_issue = 1'b0;
    logic [31:0] i_instr = 32'h0;
    logic [XLEN-1:0] i_rs_val = '0;
    logic [XLEN-1:0] i_rt_val = '0;
    logic i_mode64 = 1'b1;
    logic req_cond = 1'b0;
    logic req_usable = 1'b1;
    logic cond, usable, o_wr_en, o_redirect, o_nullify, o_cop_unusable;
    logic [4:0] o_wr_idx;
    logic [XLEN-1:0] o_wr_data, o_pc;
    int bad_count = 0;
    int total_checks = 0;

    // Clock at 200 MHz
    always #2.5 i_clk = ~i_clk;

    cond_line_model partner (.i_clk(i_clk), .i_srst(i_srst),
        .i_req_cond(req_cond), .i_req_usable(req_usable),
        .o_cond(cond), .o_usable(usable));

    logic_and_branch_exec DUT (.i_clk(i_clk), .i_srst(i_srst),
        .i_issue(i_issue), .i_instr(i_instr), .i_rs_val(i_rs_val),
        .i_rt_val(i_rt_val), .i_mode64(i_mode64),
        .i_coprocessor_condition_line(cond), .i_cop_usable(usable),
        .o_wr_en(o_wr_en), .o_wr_idx(o_wr_idx), .o_wr_data(o_wr_data),
        .o_pc(o_pc), .o_redirect(o_redirect), .o_nullify(o_nullify),
        .o_cop_unusable(o_cop_unusable));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [XLEN-1:0] got,
                         input logic [XLEN-1:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // An idle edge, then one issue; pulses are read half a cycle after the issue edge
    task automatic issue(input logic [31:0] ins,
                         input logic [XLEN-1:0] rs, rt);
        @(posedge i_clk);
        i_issue <= 1'b1;
        i_instr <= ins;
        i_rs_val <= rs;
        i_rt_val <= rt;
        @(posedge i_clk);
        i_issue <= 1'b0;
        @(negedge i_clk);
    endtask

    function automatic logic [31:0] conj_reg(input logic [4:0] rd);
        return {OPC_SPECIAL, 5'h01, 5'h02, rd, 5'h00, FUNC_CONJ};
    endfunction

    // 32-bit mode keeps addresses sign-extended from bit 31
    function automatic logic [XLEN-1:0] fix(input logic [XLEN-1:0] a);
        return i_mode64 ? a : {{32{a[31]}}, a[31:0]};
    endfunction

    // Branch, then a conjunction in its slot; judge slot and redirect
    task automatic run_br(input logic [31:0] ins,
                          input logic [XLEN-1:0] rs, rt, input logic tk, lk);
        logic [XLEN-1:0] b;
        logic [XLEN-1:0] tgt;
        b = o_pc;
        tgt = fix(b + 64'h4 + {{46{ins[15]}}, ins[15:0], 2'b00});
        issue(ins, rs, rt);
        check(o_redirect, 1'b0, "redirect before slot");
        check(o_pc, fix(b + 64'h4), "slot address");
        issue(conj_reg(5'h03), 64'hf0, 64'h3c);
        check(o_redirect, tk, "branch decision");
        check(o_pc, tk ? tgt : fix(b + 64'h8), "target");
        check(o_nullify, lk & ~tk, "slot squash");
        check(o_wr_en, !(lk && !tk), "slot write");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_conj();
        issue(conj_reg(5'h1d), 64'hff00_f0f0_1234_5678,
              64'h0ff0_ffff_00ff_ffff);
        check(o_wr_en, 1'b1, "conj write");
        check(o_wr_idx, 5'h1d, "conj index");
        check(o_wr_data, 64'h0f00_f0f0_0034_5678, "conj data");
        issue({OPC_CONJ_IMM, 5'h01, 5'h07, 16'h8f0f}, '1, '0);
        check(o_wr_idx, 5'h07, "imm index");
        check(o_wr_data, 64'h8f0f, "imm zero-extend");
        $display("test conj done");
    endtask

    task automatic t_eq();
        run_br({OPC_EQ, 10'h022, 16'hfff0}, 64'h5, 64'h5, 1, 0);
        run_br({OPC_EQ, 10'h022, 16'h0010}, 64'h5,
               64'h8000_0000_0000_0005, 0, 0);
        run_br({OPC_EQ_LIKELY, 10'h022, 16'h0020}, 5, 6, 0, 1);
        run_br({OPC_EQ_LIKELY, 10'h022, 16'h7fff}, 7, 7, 1, 1);
        $display("test equality done");
    endtask

    task automatic t_nonneg();
        run_br({OPC_REG_IMM_GROUP, 5'h04, NONNEG_CODE, 16'h8000},
               0, 0, 1, 0);
        run_br({OPC_REG_IMM_GROUP, 5'h04, NONNEG_CODE, 16'h0004},
               64'h8000_0000_0000_0000, 0, 0, 0);
        @(posedge i_clk);
        i_mode64 <= 1'b0;
        @(negedge i_clk);
        run_br({OPC_REG_IMM_GROUP, 5'h04, NONNEG_CODE, 16'hfff8},
               64'h8000_0000, 0, 0, 0);
        run_br({OPC_REG_IMM_GROUP, 5'h04, NONNEG_CODE, 16'hfff8},
               64'h8000_0000_0000_0001, 0, 1, 0);
        @(posedge i_clk);
        i_mode64 <= 1'b1;
        @(negedge i_clk);
        $display("test nonnegative done");
    endtask

    task automatic t_cop();
        logic [4:0] codes [4] = '{COND_FALSE_CODE, COND_TRUE_CODE,
                                  COND_FALSE_LIKELY_CODE,
                                  COND_TRUE_LIKELY_CODE};
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge i_clk);
                req_cond <= c[0];
                // A filler keeps the line change one issue ahead
                issue(conj_reg(5'h04), 64'h1, 64'h1);
                run_br({OPC_COP_GROUP_HI, 2'b00, COP_SUB_BRANCH, codes[k],
                        16'h0008}, 0, 0, c[0] == k[0],
                       k[1]);
            end
        end
        $display("test coprocessor branch done");
    endtask

    task automatic t_unusable();
        logic [XLEN-1:0] b;
        @(posedge i_clk);
        req_usable <= 1'b0;
        req_cond <= 1'b1;
        issue(conj_reg(5'h04), 64'h1, 64'h1);
        check(o_cop_unusable, 1'b0, "no fault on logic op");
        b = o_pc;
        issue({OPC_COP_GROUP_HI, 2'b00, COP_SUB_BRANCH, COND_TRUE_CODE,
               16'h0040}, 0, 0);
        check(o_cop_unusable, 1'b1, "unusable fault");
        issue(conj_reg(5'h04), 64'h1, 64'h1);
        check(o_redirect, 1'b0, "no branch on fault");
        check(o_pc, b + 64'h8, "sequential after fault");
        @(posedge i_clk);
        req_usable <= 1'b1;
        $display("test unusable done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        @(negedge i_clk);
        check(o_pc, PC_RESET, "reset address");
        check(o_wr_en, 1'b0, "reset write");
        check(o_redirect, 1'b0, "reset redirect");
        t_conj();
        t_eq();
        t_nonneg();
        t_cop();
        t_unusable();
        give_verdict();
    end

    // Bounded run: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        $display("[FAIL] %0t run did not finish", $time);
        give_verdict();
    end
endmodule
